// file: prog_host.sv
// programmer-side controller driving the serial programming pins
// assumes software on a plain register port; device data pin sampled via pin_sync
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "prog_params.svh"
// How it works
// - hold clock and data low, raise select, then raise master clear
// - start or program only with flash select set and config select clear; bulk erase is not gated by them
// - start only after write permit was set
// - set write permit just before an erase; bulk erase itself neither sets nor checks it
// - bulk erase code written high byte upper address, low byte lower
// - protected data EEPROM gets its own explicit erase code
// - data held low while bulk erase runs
// - software reads, buffers, erases and rewrites a changed block
// - nop with clock high for P9 then low for P10 follows starts
// - program command only after buffer is full of loads
module prog_host #(
  parameter int P9_CYC = (`P9_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int P10_CYC = (`P10_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int P11_CYC = (`P11_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wrData,
  input wire logic write_permit,
  input wire logic rdEn,
  output logic [15:0] rdData,
  output logic progClock,
  output logic progData,
  output logic progDataOe_n,
  input wire logic progDataIn,
  output logic lowVoltSelect,
  output logic masterClear
);
  import prog_pkg::*;
  localparam int ENTRY_CYC = (`ENTRY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  // -------------------------------
  // instruction builders
  // -------------------------------
  function automatic logic [15:0] mcInstr(input logic set, input logic [2:0] b);
    mcInstr = {(set ? `INS_BSF : `INS_BCF) | {4'h0, b, 1'b0}, `FR_MEMCTRL};
  endfunction
  function automatic logic [15:0] ptrInstr(input logic [21:0] a, input logic [2:0] s);
    case (s)
      3'd0: ptrInstr = {`INS_MOVLW, 2'b00, a[21:16]};
      3'd1: ptrInstr = {`INS_MOVWF, `FR_PTR_U};
      3'd2: ptrInstr = {`INS_MOVLW, a[15:8]};
      3'd3: ptrInstr = {`INS_MOVWF, `FR_PTR_H};
      3'd4: ptrInstr = {`INS_MOVLW, a[7:0]};
      default: ptrInstr = {`INS_MOVWF, `FR_PTR_L};
    endcase
  endfunction
  function automatic logic codeValid(input logic [15:0] c);
    codeValid = (c == `CODE_CHIP) || (c == `CODE_EEPROM) || (c == `CODE_BOOT) ||
      (c == `CODE_CONFIG) || ((c[7:0] == `CODE_BLOCK_LO) && c[15:14] == 2'b00 &&
      $onehot(c[13:8]));
  endfunction
  function automatic step_t stepOf(input op_t k, input logic [3:0] s,
      input logic [21:0] p, input logic [15:0] d, input logic [15:0] c,
      input logic [3:0] rc, input logic [2:0] b, input logic rd);
    step_t t;
    t = '0;
    case (k)
      OP_RAW: begin
        t.cmd = rc;
        t.payload = d;
        t.read = rd;
        t.last = 1'b1;
      end
      OP_BITSET, OP_BITCLR: begin
        t.payload = mcInstr(k == OP_BITSET, b);
        t.last = 1'b1;
      end
      OP_SETPTR: begin
        t.payload = ptrInstr(p, s[2:0]);
        t.last = (s == `PTR_LAST_STEP);
      end
      OP_LOAD: begin
        t.cmd = `CMD_LOAD;
        t.payload = d;
        t.last = 1'b1;
      end
      OP_PROG, OP_START: begin
        if (s == 4'h0) begin
          t.cmd = (k == OP_PROG) ? `CMD_PROG : `CMD_CORE;
          t.payload = (k == OP_PROG) ? d : mcInstr(1'b1, 3'(`MC_WR));
        end else begin
          t.hold = 1'b1;
          t.last = 1'b1;
        end
      end
      OP_BULK: begin
        if (s <= `PTR_LAST_STEP) begin
          t.payload = ptrInstr(`ERASE_HI_ADDR, s[2:0]);
        end else if (s == `BULK_HI_WRITE) begin
          t.cmd = `CMD_TWRITE;
          t.payload = {c[15:8], c[15:8]};
        end else if (s < `BULK_LO_WRITE) begin
          t.payload = ptrInstr(`ERASE_LO_ADDR, s[2:0] - `BULK_LO_OFS);
        end else if (s == `BULK_LO_WRITE) begin
          t.cmd = `CMD_TWRITE;
          t.payload = {c[7:0], c[7:0]};
        end else if (s == `BULK_NOP) begin
          t.payload = `NOP_WORD;
        end else begin
          t.payload = `NOP_WORD;
          t.erase = 1'b1;
          t.last = 1'b1;
        end
      end
      default: t.last = 1'b1;
    endcase
    return t;
  endfunction
  // -------------------------------
  // state
  // -------------------------------
  ser_if ser ();
  state_t state_q, state_d;
  op_t opKind_q;
  logic [2:0] mode_q;
  logic [21:0] ptr_q;
  logic [15:0] data_q, code_q, rdData_q, rdMux;
  logic [3:0] opCmd_q, step_q;
  logic [2:0] opBit_q;
  logic [7:0] shadow_q, loadCnt_q, rdByte_q;
  logic [15:0] tmr_q;
  logic opRead_q, eraseRepeat_q, refused_q, sdiSync;
  logic progClock_q, progData_q, progDataOe_n_q, lowVoltSelect_q, masterClear_q;
  // -------------------------------
  // decoding
  // -------------------------------
  wire op_t newKind = op_t'(wrData[`OPF_KIND]);
  wire opWr = write_permit && (addr == `REG_OP);
  wire codeOk = codeValid(code_q);
  wire spaceOk = shadow_q[`MC_FLASH] && !shadow_q[`MC_CFG];
  wire permitOk = spaceOk && shadow_q[`MC_PERMIT];
  wire kindOk = (newKind == OP_RAW) || (newKind == OP_SETPTR) ||
    (newKind == OP_LOAD) || (newKind == OP_BITCLR) ||
    (newKind == OP_BITSET && wrData[`OPF_BIT] != 3'(`MC_WR)) ||
    (newKind == OP_START && permitOk) ||
    (newKind == OP_PROG && permitOk && loadCnt_q == `BUF_LOADS) ||
    (newKind == OP_BULK && codeOk);
  wire accept = opWr && (state_q == ST_ACTIVE) && mode_q[`MODE_ENTER] && kindOk;
  wire reject = opWr && !accept;
  wire [15:0] curCode = eraseRepeat_q ? `CODE_EEPROM : code_q;
  wire step_t cur = stepOf(opKind_q, step_q, ptr_q, data_q, curCode, opCmd_q,
    opBit_q, opRead_q);
  wire stepDone = (state_q == ST_WAIT) && ser.done;
  wire opDone = stepDone && cur.last;
  wire repeatNeed = (opKind_q == OP_BULK) && !eraseRepeat_q &&
    (code_q == `CODE_CHIP) && mode_q[`MODE_DPROT];
  wire leaveClear = (state_q == ST_LEAVE) && shadow_q[`MC_PERMIT];
  wire inModeD = (state_d == ST_ACTIVE) || (state_d == ST_RUN) ||
    (state_d == ST_WAIT) || (state_d == ST_LEAVE);
  wire selectD = (state_d != ST_OFF) && mode_q[`MODE_LOWV];
  assign ser.req = (state_q == ST_RUN);
  assign ser.cmd = cur.cmd;
  assign ser.payload = cur.payload;
  assign ser.holdNop = cur.hold;
  assign ser.eraseWait = cur.erase;
  assign ser.readBack = cur.read;
  assign ser.sdi = sdiSync;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (mode_q[`MODE_ENTER] && mode_q[`MODE_LOWV]) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_q == 16'h0) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!mode_q[`MODE_ENTER]) begin
          state_d = ST_LEAVE;
        end else if (accept) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: state_d = ST_WAIT;
      ST_WAIT: begin
        if (opDone) begin
          state_d = repeatNeed ? ST_RUN : ST_ACTIVE;
        end else if (stepDone) begin
          state_d = ST_RUN;
        end
      end
      ST_LEAVE: state_d = leaveClear ? ST_RUN : ST_OFF;
      default: state_d = ST_OFF;
    endcase
  end
  always_comb begin
    rdMux = 16'h0;
    if (addr == `REG_MODE) begin
      rdMux = {13'h0, mode_q};
    end else if (addr == `REG_ADDR_LO) begin
      rdMux = ptr_q[15:0];
    end else if (addr == `REG_ADDR_HI) begin
      rdMux = {10'h0, ptr_q[21:16]};
    end else if (addr == `REG_DATA) begin
      rdMux = data_q;
    end else if (addr == `REG_CODE) begin
      rdMux = code_q;
    end else if (addr == `REG_STATUS) begin
      rdMux = {12'h0, eraseRepeat_q, refused_q, state_q != ST_ACTIVE && state_q != ST_OFF,
        masterClear_q};
    end else if (addr == `REG_SHADOW) begin
      rdMux = {rdByte_q, shadow_q};
    end else if (addr == `REG_LOADS) begin
      rdMux = {8'h0, loadCnt_q};
    end
  end
  // -------------------------------
  // registers
  // -------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      mode_q <= 3'h0;
      data_q <= 16'h0;
      code_q <= 16'h0;
      rdData_q <= 16'h0;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdData_q <= rdEn ? rdMux : 16'h0;
      if (write_permit && addr == `REG_MODE) begin
        mode_q <= wrData[`MODE_BITS];
      end
      if (write_permit && addr == `REG_DATA) begin
        data_q <= wrData;
      end
      if (write_permit && addr == `REG_CODE) begin
        code_q <= wrData;
      end
      if (reject) begin
        refused_q <= 1'b1;
      end else if (write_permit && addr == `REG_STATUS && wrData[`ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opKind_q <= OP_NONE;
      opCmd_q <= 4'h0;
      opBit_q <= 3'h0;
      opRead_q <= 1'b0;
      step_q <= 4'h0;
      eraseRepeat_q <= 1'b0;
    end else if (accept) begin
      opKind_q <= newKind;
      opCmd_q <= wrData[`OPF_CMD];
      opBit_q <= wrData[`OPF_BIT];
      opRead_q <= wrData[`OPF_READ];
      step_q <= 4'h0;
      eraseRepeat_q <= 1'b0;
    end else if (leaveClear) begin
      opKind_q <= OP_BITCLR;
      opBit_q <= 3'(`MC_PERMIT);
      step_q <= 4'h0;
    end else if (opDone && repeatNeed) begin
      step_q <= 4'h0;
      eraseRepeat_q <= 1'b1;
    end else if (stepDone && !cur.last) begin
      step_q <= step_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q <= 22'h0;
      shadow_q <= 8'h0;
      loadCnt_q <= 8'h0;
      rdByte_q <= 8'h0;
    end else begin
      if (opDone && opKind_q == OP_LOAD) begin
        ptr_q <= ptr_q + `PTR_STEP;
      end else if (write_permit && addr == `REG_ADDR_LO) begin
        ptr_q[15:0] <= wrData;
      end else if (write_permit && addr == `REG_ADDR_HI) begin
        ptr_q[21:16] <= wrData[`ADDR_HI_BITS];
      end
      if (opDone && opKind_q == OP_BITSET) begin
        shadow_q[opBit_q] <= 1'b1;
      end else if (opDone && opKind_q == OP_BITCLR) begin
        shadow_q[opBit_q] <= 1'b0;
      end else if (state_q == ST_OFF) begin
        shadow_q <= 8'h0;
      end
      if (opDone && opKind_q == OP_LOAD) begin
        loadCnt_q <= loadCnt_q + 8'h1;
      end else if ((opDone && opKind_q == OP_PROG) || state_q == ST_OFF) begin
        loadCnt_q <= 8'h0;
      end
      if (opDone && opKind_q == OP_RAW && opRead_q) begin
        rdByte_q <= ser.rdByte;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_q <= 16'h0;
      progClock_q <= 1'b0;
      progData_q <= 1'b0;
      progDataOe_n_q <= 1'b0;
      lowVoltSelect_q <= 1'b0;
      masterClear_q <= 1'b0;
    end else begin
      tmr_q <= (state_q == ST_OFF) ? 16'(ENTRY_CYC - 1) :
        (tmr_q != 16'h0) ? tmr_q - 16'h1 : tmr_q;
      progClock_q <= inModeD && ser.sck;
      progData_q <= inModeD && ser.sdo;
      progDataOe_n_q <= inModeD && !ser.sdoDrive;
      lowVoltSelect_q <= selectD;
      masterClear_q <= inModeD;
    end
  end
  assign rdData = rdData_q;
  assign progClock = progClock_q;
  assign progData = progData_q;
  assign progDataOe_n = progDataOe_n_q;
  assign lowVoltSelect = lowVoltSelect_q;
  assign masterClear = masterClear_q;
  // -------------------------------
  // submodules
  // -------------------------------
  pin_sync u_sync (.clk(clk), .rst_n(rst_n), .pinIn(progDataIn), .pinOut(sdiSync));
  serial_shifter #(.P9C(P9_CYC), .P10C(P10_CYC), .P11C(P11_CYC)) u_shift (
    .clk(clk), .rst_n(rst_n), .ser(ser.engine));
  // -------------------------------
  // checks
  // -------------------------------
  a_entry_order: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(masterClear_q) |-> ($past(lowVoltSelect_q) && !$past(progClock_q) &&
    !$past(progData_q)))
    else $error("master clear raised out of order");
  a_select_gate: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lowVoltSelect_q) |-> mode_q[`MODE_LOWV])
    else $error("select raised without low-voltage enable");
  a_start_guard: assert property (@(posedge clk) disable iff (!rst_n)
    (ser.req && (opKind_q == OP_START || opKind_q == OP_PROG) && step_q == 4'h0)
    |-> (shadow_q[`MC_PERMIT] && shadow_q[`MC_FLASH] && !shadow_q[`MC_CFG]))
    else $error("start without permit or flash space");
  a_buffer_full: assert property (@(posedge clk) disable iff (!rst_n)
    (ser.req && opKind_q == OP_PROG && step_q == 4'h0) |-> loadCnt_q == `BUF_LOADS)
    else $error("program start before buffer full");
  a_nop_after: assert property (@(posedge clk) disable iff (!rst_n)
    (stepDone && (opKind_q == OP_START || opKind_q == OP_PROG) && step_q == 4'h0)
    |=> (ser.req && ser.holdNop && ser.cmd == `CMD_CORE ##1 state_q == ST_WAIT))
    else $error("no timed nop after start");
  a_code_valid: assert property (@(posedge clk) disable iff (!rst_n)
    (ser.req && opKind_q == OP_BULK && step_q == `BULK_HI_WRITE) |-> codeValid(curCode))
    else $error("bulk erase with bad code");
  a_eeprom_extra: assert property (@(posedge clk) disable iff (!rst_n)
    (opDone && repeatNeed) |=> (state_q == ST_RUN && eraseRepeat_q && step_q == 4'h0))
    else $error("protected eeprom erase not issued");
  a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_n)
    (opDone && opKind_q == OP_LOAD) |=> ptr_q == $past(ptr_q) + `PTR_STEP)
    else $error("pointer not advanced by two");
  a_permit_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(masterClear_q) |-> !shadow_q[`MC_PERMIT])
    else $error("left mode with write permit set");
endmodule // prog_host
`default_nettype wire

// file: prog_params.svh
// constants for the serial flash programming controller
// assumes a 100 MHz system clock and word-indexed own registers
`ifndef PROG_PARAMS_SVH
`define PROG_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define ENTRY_TIME_NS 2000
`define P9_TIME_NS 1000000
`define P10_TIME_NS 100000
`define P11_TIME_NS 5000000
`define SCK_HALF_CYC 32'd5
`define REG_MODE 4'h0
`define REG_ADDR_LO 4'h1
`define REG_ADDR_HI 4'h2
`define REG_DATA 4'h3
`define REG_CODE 4'h4
`define REG_OP 4'h5
`define REG_STATUS 4'h6
`define REG_SHADOW 4'h7
`define REG_LOADS 4'h8
`define MODE_ENTER 0
`define MODE_LOWV 1
`define MODE_DPROT 2
`define MODE_BITS 2:0
`define OPF_KIND 3:0
`define OPF_CMD 7:4
`define OPF_BIT 10:8
`define OPF_READ 11
`define ST_REFUSED 2
`define ADDR_HI_BITS 5:0
`define MC_FLASH 7
`define MC_CFG 6
`define MC_FREE 4
`define MC_PERMIT 2
`define MC_WR 1
`define CMD_CORE 4'h0
`define CMD_TWRITE 4'hc
`define CMD_LOAD 4'hd
`define CMD_PROG 4'hf
`define INS_MOVLW 8'h0e
`define INS_MOVWF 8'h6e
`define INS_BSF 8'h80
`define INS_BCF 8'h90
`define FR_PTR_U 8'hf8
`define FR_PTR_H 8'hf7
`define FR_PTR_L 8'hf6
`define FR_MEMCTRL 8'ha6
`define NOP_WORD 16'h0000
`define ERASE_LO_ADDR 22'h3c0004
`define ERASE_HI_ADDR 22'h3c0005
`define CODE_CHIP 16'h3f8f
`define CODE_EEPROM 16'h0084
`define CODE_BOOT 16'h0081
`define CODE_CONFIG 16'h0082
`define CODE_BLOCK_LO 8'h80
`define PTR_LAST_STEP 4'd5
`define BULK_HI_WRITE 4'd6
`define BULK_LO_WRITE 4'd9
`define BULK_NOP 4'd10
`define BULK_WAIT 4'd11
`define BULK_LO_OFS 3'd3
`define BUF_LOADS 8'd15
`define PTR_STEP 22'd2
`define LAST_BIT 5'd19
`define NOP_CLK_BIT 5'd3
`define READ_FIRST_BIT 5'd12
`endif

// file: prog_pkg.sv
// types for the serial flash programming controller
// assumes prog_params.svh for all numeric constants
package prog_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, ST_SETUP = 3'b001, ST_ACTIVE = 3'b010,
    ST_RUN = 3'b011, ST_WAIT = 3'b100, ST_LEAVE = 3'b101
  } state_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_RAW = 4'h1, OP_BITSET = 4'h2, OP_BITCLR = 4'h3,
    OP_SETPTR = 4'h4, OP_LOAD = 4'h5, OP_PROG = 4'h6, OP_START = 4'h7,
    OP_BULK = 4'h8
  } op_t;
  typedef struct packed {
    logic [3:0] cmd;
    logic [15:0] payload;
    logic hold;
    logic erase;
    logic read;
    logic last;
  } step_t;
endpackage

// file: ser_if.sv
// carrier between the sequencer and the serial shifter
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface ser_if;
  logic req;
  logic [3:0] cmd;
  logic [15:0] payload;
  logic holdNop;
  logic eraseWait;
  logic readBack;
  logic sdi;
  logic done;
  logic busy;
  logic [7:0] rdByte;
  logic sck;
  logic sdo;
  logic sdoDrive;
  modport ctrl (output req, cmd, payload, holdNop, eraseWait, readBack, sdi,
    input done, busy, rdByte, sck, sdo, sdoDrive);
  modport engine (input req, cmd, payload, holdNop, eraseWait, readBack, sdi,
    output done, busy, rdByte, sck, sdo, sdoDrive);
endinterface
`default_nettype wire

// file: pin_sync.sv
// three-stage synchroniser for a pin input
// assumes an asynchronous input; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic pinOut
);
  logic s1_q, s2_q, s3_q, out_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end
  assign pinOut = out_q;
endmodule // pin_sync
`default_nettype wire

// file: serial_shifter.sv
// shifts one 4-bit command and 16-bit payload out, lsb first
// assumes req is a one-cycle pulse taken only while idle
`timescale 1ns/1ps
`default_nettype none
`include "prog_params.svh"
module serial_shifter #(
  parameter int P9C = 1,
  parameter int P10C = 1,
  parameter int P11C = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  ser_if.engine ser
);
  import prog_pkg::*;
  logic [19:0] shift_q;
  logic [4:0] bit_q;
  logic [31:0] tmr_q;
  logic [7:0] rd_q;
  logic active_q, high_q, hold_q, erase_q, read_q, done_q, sck_q, sdo_q, drv_q;
  wire phaseEnd = active_q && (tmr_q == 32'h0);
  wire lastBit = (bit_q == `LAST_BIT);
  wire fourth = (bit_q == `NOP_CLK_BIT);
  wire [4:0] nextBit = bit_q + 5'h1;
  wire nextFourth = (nextBit == `NOP_CLK_BIT);
  wire [31:0] halfLen = `SCK_HALF_CYC - 32'h1;
  wire [31:0] highLen = (hold_q && nextFourth) ? 32'(P9C - 1) : halfLen;
  wire [31:0] lowLen = !fourth ? halfLen : hold_q ? 32'(P10C - 1) :
    erase_q ? 32'(P11C - 1) : halfLen;
  // -------------------------------
  // bit timing
  // -------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_q <= 20'h0;
      bit_q <= 5'h0;
      tmr_q <= 32'h0;
      rd_q <= 8'h0;
      active_q <= 1'b0;
      high_q <= 1'b0;
      hold_q <= 1'b0;
      erase_q <= 1'b0;
      read_q <= 1'b0;
      done_q <= 1'b0;
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      drv_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!active_q) begin
        if (ser.req) begin
          shift_q <= {ser.payload, ser.cmd};
          hold_q <= ser.holdNop;
          erase_q <= ser.eraseWait;
          read_q <= ser.readBack;
          bit_q <= 5'h0;
          active_q <= 1'b1;
          high_q <= 1'b1;
          sck_q <= 1'b1;
          sdo_q <= ser.cmd[0];
          tmr_q <= halfLen;
        end
      end else if (phaseEnd) begin
        // readback taken at end of low phase: pin flop plus sync delay fill the low phase
        if (!high_q && read_q && bit_q >= `READ_FIRST_BIT) begin
          rd_q <= {ser.sdi, rd_q[7:1]};
        end
        if (high_q) begin
          high_q <= 1'b0;
          sck_q <= 1'b0;
          tmr_q <= lowLen;
        end else if (lastBit) begin
          active_q <= 1'b0;
          done_q <= 1'b1;
          sdo_q <= 1'b0;
          drv_q <= 1'b1;
        end else begin
          bit_q <= nextBit;
          high_q <= 1'b1;
          sck_q <= 1'b1;
          sdo_q <= shift_q[nextBit];
          drv_q <= !(read_q && nextBit >= `READ_FIRST_BIT);
          tmr_q <= highLen;
        end
      end else begin
        tmr_q <= tmr_q - 32'h1;
      end
    end
  end
  assign ser.done = done_q;
  assign ser.busy = active_q;
  assign ser.rdByte = rd_q;
  assign ser.sck = sck_q;
  assign ser.sdo = sdo_q;
  assign ser.sdoDrive = drv_q;
  // -------------------------------
  // checks
  // -------------------------------
  a_erase_data_low: assert property (@(posedge clk) disable iff (!rst_n)
    (active_q && erase_q && fourth && !high_q) |-> (!sdo_q && drv_q && !sck_q))
    else $error("data not held low during bulk erase");
  a_hold_high_len: assert property (@(posedge clk) disable iff (!rst_n)
    (phaseEnd && !high_q && hold_q && nextFourth) |=> (sck_q && tmr_q == 32'(P9C - 1)))
    else $error("nop clock high time wrong");
endmodule // serial_shifter
`default_nettype wire

// file: prog_device.sv
// device model: takes serial frames from the host, answers readback
// assumes host moves data on rising clock; device samples on falling
`timescale 1ns/1ps
`default_nettype none
module prog_device (
  input wire logic progClock,
  input wire logic progData,
  input wire logic progDataOe_n,
  input wire logic lowVoltSelect,
  input wire logic masterClear,
  output logic pinLevel
);
  logic [19:0] fr [0:511];
  logic [19:0] sh;
  logic inMode;
  logic [7:0] rbByte = 8'hb4;
  int k;
  int n;
  // released line shows inverse, last 8 payload bits show readback byte
  assign pinLevel = progDataOe_n ? (k >= 12 ? rbByte[k - 12] : ~progData) : progData;
  initial begin
    k = 0;
    n = 0;
    inMode = 0;
  end
  // mode entry only with clock and data low and select high
  // bit count restarts at entry, so the clock's fall out of reset is not counted
  always @(posedge masterClear) begin
    inMode = lowVoltSelect & ~progClock & ~progData;
    k = 0;
  end
  always @(negedge masterClear) inMode = 0;
  // frame capture, lsb first: {payload, cmd}
  always @(negedge progClock) begin
    sh = {pinLevel, sh[19:1]};
    k = k + 1;
    if (k == 20) begin
      fr[n] = sh;
      n = n + 1;
      k = 0;
    end
  end
endmodule // prog_device
`default_nettype wire

// file: prog_host_tb.sv
// bench: prog_host over its register port, device model on the pins
// assumes shortened P9/P10/P11 counts
`timescale 1ns/1ps
`default_nettype none
module prog_host_tb;
  logic clk = 0, rst_n = 0, write_permit = 0, rdEn = 0;
  logic [3:0] addr = '0;
  logic [15:0] wrData = '0, rdData, s;
  logic progClock, progData, progDataOe_n, lowVoltSelect, masterClear, pin;
  int errors = 0, checks_done = 0, cyc = 0, n0;
  always #5 clk = ~clk;
  prog_host #(.P9_CYC(20), .P10_CYC(20), .P11_CYC(40)) i_dut (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wrData(wrData), .write_permit(write_permit), .rdEn(rdEn), .rdData(rdData),
    .progClock(progClock), .progData(progData), .progDataOe_n(progDataOe_n),
    .progDataIn(pin), .lowVoltSelect(lowVoltSelect), .masterClear(masterClear));
  prog_device dev (.progClock(progClock), .progData(progData), .progDataOe_n(progDataOe_n),
    .lowVoltSelect(lowVoltSelect), .masterClear(masterClear), .pinLevel(pin));
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) addr <= a;
    wrData <= d;
    write_permit <= 1;
    @(posedge clk) write_permit <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk) addr <= a;
    rdEn <= 1;
    @(posedge clk) rdEn <= 0;
    #1 s = rdData;
  endtask
  task automatic op(input logic [15:0] o);
    n0 = dev.n;
    wr(5, o);
    rd(6);
    for (int i = 0; i < 20000 && s[1] !== 1'b0; i++) rd(6);
    chk(s[1], 1'b0);
  endtask
  task automatic t_basic;
    chk({progClock, progData, progDataOe_n, lowVoltSelect, masterClear}, '0);
    rd(15);
    chk(s, '0);
    op(16'h0007);
    rd(6);
    chk(s, 16'h0004);
    wr(0, 16'h0001);
    repeat (300) @(posedge clk);
    chk({lowVoltSelect, masterClear}, '0);
    wr(0, 16'h0003);
    repeat (3) @(posedge clk);
    chk({lowVoltSelect, masterClear, progClock, progData}, 20'h00008);
    for (int i = 0; i < 400 && s[0] !== 1'b1; i++) rd(6);
    chk({masterClear, dev.inMode}, 20'h00003);
  endtask
  task automatic t_ops;
    op(16'h0702);
    chk(dev.fr[n0], 20'h8ea60);
    op(16'h0603);
    chk(dev.fr[n0], 20'h9ca60);
    wr(6, 16'h0004);
    op(16'h0007);
    rd(6);
    chk(s[2], 1'b1);
    op(16'h0202);
    op(16'h0402);
    op(16'h0007);
    chk(dev.fr[n0], 20'h82a60);
    chk(dev.fr[n0 + 1], '0);
    wr(1, 16'h0100);
    wr(2, 16'h0021);
    op(16'h0004);
    chk(dev.fr[n0], 20'h0e210);
    chk(dev.fr[n0 + 2], 20'h0e010);
    chk(dev.fr[n0 + 5], 20'h6ef60);
    for (int i = 0; i < 15; i++) begin
      wr(3, 16'h1230 + i[15:0]);
      op(16'h0005);
      chk(dev.fr[n0], {16'h1230 + i[15:0], 4'hd});
    end
    rd(1);
    chk(s, 16'h011e);
    rd(8);
    chk(s, 16'h000f);
    wr(3, 16'hbeef);
    op(16'h0006);
    chk(dev.fr[n0], 20'hbeeff);
    chk(dev.fr[n0 + 1], '0);
    op(16'h0891);
    rd(7);
    chk(s[15:8], 8'hb4);
  endtask
  task automatic t_bulk;
    logic [15:0] cd [10] = '{16'h3f8f, 16'h0081, 16'h0082, 16'h0180, 16'h0280,
      16'h0480, 16'h0880, 16'h1080, 16'h2080, 16'h0084};
    wr(0, 16'h0007);
    for (int i = 0; i < 10; i++) begin
      wr(4, cd[i]);
      op(16'h0008);
      chk(dev.fr[n0 + 6], {cd[i][15:8], cd[i][15:8], 4'hc});
      chk(dev.fr[n0 + 9], {cd[i][7:0], cd[i][7:0], 4'hc});
      chk(20'(dev.n - n0), i ? 20'h0000c : 20'h00018);
      if (i == 0) chk(dev.fr[n0 + 21], 20'h8484c);
      wr(0, 16'h0003);
    end
    chk(dev.fr[n0 + 4], 20'h0e050);
    chk(dev.fr[n0 + 7], 20'h0e040);
    n0 = dev.n;
    wr(0, '0);
    for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) rd(6);
    chk(dev.fr[n0], 20'h94a60);
    chk({lowVoltSelect, masterClear, dev.inMode}, '0);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    t_basic;
    t_ops;
    t_bulk;
    test_done;
  end
endmodule // prog_host_tb
`default_nettype wire
